// file: inc/can_mailbox_defines.vh
// register offsets, field positions and reset values of the mailbox store
// included by the mailbox store module; definitions only
`ifndef CAN_MAILBOX_DEFINES_VH
`define CAN_MAILBOX_DEFINES_VH
// per-mailbox word offsets inside a mailbox block
`define MB_WORD_CTRL 2'h0
`define MB_WORD_LEN 2'h1
`define MB_WORD_DLO 2'h2
`define MB_WORD_DHI 2'h3
// mailbox block base index: addr[7:4]; tx 0..2, rx 3..4
`define MB_RX_BASE 4'h3
`define MB_RX_LAST 4'h4
// fields
`define LEN_STAMP_HI 31
`define LEN_STAMP_LO 16
`define LEN_FILT_HI 15
`define LEN_FILT_LO 8
`define LEN_STAMP_EN 8
`define LEN_COUNT_HI 3
`define SEND_REQ_BIT 0
`define MAX_BYTES 4'h8
`define FIFO_DEPTH 3
`define RESET_WORD 32'h00000000
`define ERR_ADDR_RESP 1'b1
`endif

// file: verilog/can_mailbox_message_store.v
// message storage of a can controller: three tx mailboxes, two 3-deep rx fifos
// assumes an apb master on core_clk, and a protocol engine on the same clock
// Notes on behaviour
// - tx mailbox writes ignored while message pending
// - timer captured into tx stamp at sof
// - stamp send enable only in time-triggered mode
// - stamp bytes replace data bytes six, seven
// - tx byte count in bits 3:0, 0..8; the register keeps 9..15 and reads them back, and the engine gets 8
// - data bytes little-endian in low/high words
// - rx identifier bits 31:21 and 20:3
// - rx bit 2 shows identifier format
// - rx bit 1 frame kind, bit 0 zero
// - rx mailbox registers read-only to software
// - rx stamp stored in bits 31:16
// - rx filter hit number in bits 15:8
// - rx length 0..8, zero for remote
// - request bit set by software, hardware clears
// - three tx mailboxes, two 3-level rx fifos
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "can_mailbox_defines.vh"
module can_mailbox_message_store (
	// clock and reset
	input wire core_clk,
	input wire sys_rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// protocol engine side
	input wire [15:0] can_timer,
	input wire time_trig_mode,
	input wire [1:0] tx_sof_sel,
	input wire tx_sof,
	input wire [1:0] tx_done_sel,
	input wire tx_done,
	input wire [1:0] tx_read_sel,
	output reg [2:0] tx_send_request,
	output reg [3:0] tx_byte_count_out,
	output reg [63:0] tx_frame_data,
	// receive write side
	input wire rx_push,
	input wire rx_push_fifo,
	input wire [28:0] rx_ident_in,
	input wire rx_ident_format_in,
	input wire rx_frame_kind_in,
	input wire [15:0] rx_stamp_in,
	input wire [7:0] rx_filter_in,
	input wire [3:0] rx_byte_count_in,
	input wire [63:0] rx_data_in,
	input wire [1:0] rx_release,
	output reg [3:0] rx_fill_levels,
	output reg [1:0] rx_overrun_r
);
	// tx mailbox views; each mailbox keeps its own flops in its generate pass
	// so that no register is written from more than one process
	wire [31:0] tx_ident_w [0:2];
	wire [15:0] tx_stamp_w [0:2];
	wire [2:0] tx_stamp_send_enable_w;
	wire [3:0] tx_byte_count_w [0:2];
	wire [31:0] tx_dlo_w [0:2];
	wire [31:0] tx_dhi_w [0:2];
	// per-mailbox request set and clear, merged in one process below
	wire [2:0] tx_req_set;
	wire [2:0] tx_req_clr;
	// rx fifo storage: entry = fifo*3 + slot
	reg [31:0] rx_id_mem [0:5];
	reg [31:0] rx_len_mem [0:5];
	reg [31:0] rx_dlo_mem [0:5];
	reg [31:0] rx_dhi_mem [0:5];
	reg [1:0] rx_head_r [0:1];
	reg [1:0] rx_cnt_r [0:1];
	wire [3:0] blk;
	wire [1:0] wsel;
	wire wr_acc;
	wire rd_acc;
	reg [31:0] rd_nxt;
	reg err_nxt;
	integer i;
	assign blk = paddr[7:4];
	assign wsel = paddr[3:2];
	// pready is registered: one wait cycle per access
	assign wr_acc = psel & penable & pwrite & ~pready;
	assign rd_acc = psel & penable & ~pwrite & ~pready;
	// wrap helper for a 3-slot ring
	function [1:0] ring_inc;
		input [1:0] v;
		begin
			ring_inc = (v == 2'h2) ? 2'h0 : v + 2'h1;
		end
	endfunction
	// stored byte count clipped to the legal range
	function [3:0] clip_count;
		input [3:0] c;
		begin
			clip_count = (c > `MAX_BYTES) ? `MAX_BYTES : c;
		end
	endfunction
	// tx mailboxes, one per generate pass
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : gen_tx
			reg [31:0] ident_r;
			reg [15:0] stamp_r;
			reg en_r;
			reg [3:0] count_r;
			reg [31:0] dlo_r;
			reg [31:0] dhi_r;
			wire hit;
			wire pend;
			assign hit = (blk == g) & wr_acc;
			assign pend = tx_send_request[g];
			// done wins over a same-cycle set; a set needs an empty mailbox anyway
			assign tx_req_clr[g] = tx_done & (tx_done_sel == g);
			assign tx_req_set[g] = hit & (wsel == `MB_WORD_CTRL) & ~pend
				& pwdata[`SEND_REQ_BIT];
			// exported views for the read mux and the engine side
			assign tx_ident_w[g] = ident_r;
			assign tx_stamp_w[g] = stamp_r;
			assign tx_stamp_send_enable_w[g] = en_r;
			assign tx_byte_count_w[g] = count_r;
			assign tx_dlo_w[g] = dlo_r;
			assign tx_dhi_w[g] = dhi_r;
			always @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					ident_r <= `RESET_WORD;
					stamp_r <= 16'h0000;
					en_r <= 1'b0;
					count_r <= 4'h0;
					dlo_r <= `RESET_WORD;
					dhi_r <= `RESET_WORD;
				end
				else
				begin
					// identifier word only while empty; bit 0 lives in the request flops
					if (!tx_req_clr[g] && hit && wsel == `MB_WORD_CTRL && !pend)
						ident_r <= {pwdata[31:1], 1'b0};
					// the timer is sampled by the engine's start-of-frame strobe
					if (tx_sof && tx_sof_sel == g)
						stamp_r <= can_timer;
					// data words frozen while pending
					if (hit && !pend)
					begin
						if (wsel == `MB_WORD_LEN)
						begin
							en_r <= pwdata[`LEN_STAMP_EN];
							count_r <= pwdata[`LEN_COUNT_HI:0];
						end
						if (wsel == `MB_WORD_DLO)
							dlo_r <= pwdata;
						if (wsel == `MB_WORD_DHI)
							dhi_r <= pwdata;
					end
				end
			end
		end
	endgenerate
	// send requests of all mailboxes in one process: one driver for the vector
	always @(posedge core_clk)
	begin
		if (sys_rst)
			tx_send_request <= 3'b000;
		else
			tx_send_request <= (tx_send_request | tx_req_set) & ~tx_req_clr;
	end
	// frame data seen by the engine, stamp substituted
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			tx_frame_data <= 64'h0000000000000000;
			tx_byte_count_out <= 4'h0;
		end
		else
		begin
			// an over-long count is kept and read back as written, but never passed to the engine above eight
			tx_byte_count_out <= clip_count(tx_byte_count_w[tx_read_sel]);
			tx_frame_data <= {tx_dhi_w[tx_read_sel], tx_dlo_w[tx_read_sel]};
			// only honoured in time-triggered mode
			if (time_trig_mode && tx_stamp_send_enable_w[tx_read_sel])
			begin
				// byte 7 = stamp low, byte 6 = stamp high; length 8 left to software
				tx_frame_data[63:48] <= {tx_stamp_w[tx_read_sel][7:0],
					tx_stamp_w[tx_read_sel][15:8]};
			end
		end
	end
	// rx fifos: push at tail, release pops head
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			for (i = 0; i < 2; i = i + 1)
			begin
				rx_head_r[i] <= 2'h0;
				rx_cnt_r[i] <= 2'h0;
			end
			rx_overrun_r <= 2'b00;
			rx_fill_levels <= 4'h0;
		end
		else
		begin
			for (i = 0; i < 2; i = i + 1)
			begin : fifo_upd
				reg do_push;
				reg do_pop;
				reg [2:0] tail;
				do_push = rx_push && (rx_push_fifo == i) && (rx_cnt_r[i] != `FIFO_DEPTH);
				do_pop = rx_release[i] && (rx_cnt_r[i] != 2'h0);
				// head 2 plus count 2 needs a third bit before the wrap
				tail = {1'b0, rx_head_r[i]} + {1'b0, rx_cnt_r[i]};
				if (tail > 3'h2)
					tail = tail - 3'h3;
				if (rx_push && (rx_push_fifo == i) && (rx_cnt_r[i] == `FIFO_DEPTH))
					rx_overrun_r[i] <= 1'b1;
				if (do_push)
				begin
					rx_id_mem[i * 3 + tail] <= {rx_ident_in, rx_ident_format_in,
						rx_frame_kind_in, 1'b0};
					rx_len_mem[i * 3 + tail] <= {rx_stamp_in, rx_filter_in, 4'h0,
						rx_frame_kind_in ? 4'h0 : clip_count(rx_byte_count_in)};
					rx_dlo_mem[i * 3 + tail] <= rx_data_in[31:0];
					rx_dhi_mem[i * 3 + tail] <= rx_data_in[63:32];
				end
				if (do_pop)
					rx_head_r[i] <= ring_inc(rx_head_r[i]);
				rx_cnt_r[i] <= rx_cnt_r[i] + {1'b0, do_push} - {1'b0, do_pop};
			end
			rx_fill_levels <= {rx_cnt_r[1], rx_cnt_r[0]};
		end
	end
	// read mux; rx exposes only the oldest entry
	always @*
	begin : rd_mux
		reg [2:0] e;
		e = 3'h0;
		rd_nxt = `RESET_WORD;
		err_nxt = 1'b0;
		if (blk < `MB_RX_BASE)
		begin
			case (wsel)
				`MB_WORD_CTRL: rd_nxt = tx_ident_w[blk[1:0]] | {31'h0, tx_send_request[blk[1:0]]};
				`MB_WORD_LEN: rd_nxt = {tx_stamp_w[blk[1:0]], 7'h00,
					tx_stamp_send_enable_w[blk[1:0]], 4'h0, tx_byte_count_w[blk[1:0]]};
				`MB_WORD_DLO: rd_nxt = tx_dlo_w[blk[1:0]];
				default: rd_nxt = tx_dhi_w[blk[1:0]];
			endcase
		end
		else if (blk <= `MB_RX_LAST)
		begin
			// writes here fall through untouched
			e = (blk == `MB_RX_BASE) ? {1'b0, rx_head_r[0]} : 3'h3 + {1'b0, rx_head_r[1]};
			case (wsel)
				`MB_WORD_CTRL: rd_nxt = rx_id_mem[e];
				`MB_WORD_LEN: rd_nxt = rx_len_mem[e];
				`MB_WORD_DLO: rd_nxt = rx_dlo_mem[e];
				default: rd_nxt = rx_dhi_mem[e];
			endcase
		end
		else
			err_nxt = `ERR_ADDR_RESP;
	end
	// apb answer: pready one cycle after access phase begins
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `RESET_WORD;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & err_nxt;
			if (rd_acc)
				prdata <= err_nxt ? `RESET_WORD : rd_nxt;
		end
	end
endmodule // can_mailbox_message_store
`default_nettype wire

// file: bench/can_mailbox_chk.sv
// assertions on the store's apb and engine-side ports
// assumes it is bound into the store; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_chk (
	// watched ports
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] paddr,
	input wire logic tx_done,
	input wire logic [1:0] tx_done_sel,
	input wire logic [2:0] tx_send_request,
	input wire logic [3:0] tx_byte_count_out,
	input wire logic rx_push,
	input wire logic [1:0] rx_overrun_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// apb answer timing and error
	property p_ans; psel && penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_err; pready |-> pslverr == $past(paddr >= 8'h50); endproperty
	a_err: assert property (p_err) else $error("bad error");
	property p_rsp; pslverr |-> pready; endproperty
	a_rsp: assert property (p_rsp) else $error("lone error");
	// done clears the served request; count never above eight
	property p_done; tx_done |=> !tx_send_request[$past(tx_done_sel)]; endproperty
	a_done: assert property (p_done) else $error("request kept");
	property p_cnt; tx_byte_count_out <= 4'h8; endproperty
	a_cnt: assert property (p_cnt) else $error("count over");
	// overrun needs a push and then sticks
	property p_ovr; $rose(rx_overrun_r[0]) |-> $past(rx_push); endproperty
	a_ovr: assert property (p_ovr) else $error("stray overrun");
	property p_keep; rx_overrun_r[0] |=> rx_overrun_r[0]; endproperty
	a_keep: assert property (p_keep) else $error("overrun lost");
	c_err: cover property (pslverr);
	c_done: cover property (tx_done);
	c_ovr: cover property (rx_overrun_r[0]);
endmodule // can_mailbox_chk
`default_nettype wire

// file: bench/can_node_model.sv
// remote node: answers a send request with start-of-frame, then done
// assumes the engine ports on core_clk; gap sets how slowly it answers
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
	// clock, pace, requests, frame events
	input wire logic core_clk,
	input wire logic [3:0] gap,
	input wire logic [2:0] tx_send_request,
	output logic tx_sof,
	output logic [1:0] tx_sof_sel,
	output logic tx_done,
	output logic [1:0] tx_done_sel
);
	logic [1:0] m;
	// lowest pending mailbox first; lost arbitration is not modelled
	initial
	begin
		{tx_sof, tx_sof_sel, tx_done, tx_done_sel} = '0;
		forever
		begin
			@(posedge core_clk);
			if (tx_send_request != 3'h0)
			begin
				m = tx_send_request[0] ? 2'h0 : tx_send_request[1] ? 2'h1 : 2'h2;
				repeat (gap) @(posedge core_clk);
				{tx_sof, tx_sof_sel, tx_done_sel} <= {1'b1, m, m};
				@(posedge core_clk) tx_sof <= 1'b0;
				repeat (gap) @(posedge core_clk);
				tx_done <= 1'b1;
				@(posedge core_clk) tx_done <= 1'b0;
			end
		end
	end
endmodule // can_node_model
`default_nettype wire

// file: bench/can_mailbox_message_store_tb.sv
// bench for the mailbox store: apb tasks, pushed frames, node model sends
// assumes store, node model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_message_store_tb;
	// dut, model and bench signals
	logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, time_trig_mode, tx_sof;
	logic tx_done, rx_push, rx_push_fifo, rx_ident_format_in, rx_frame_kind_in, err;
	logic [1:0] tx_sof_sel, tx_done_sel, tx_read_sel, rx_release, rx_overrun_r;
	logic [2:0] tx_send_request;
	logic [3:0] tx_byte_count_out, rx_byte_count_in, rx_fill_levels, gap;
	logic [7:0] paddr, rx_filter_in;
	logic [15:0] can_timer, rx_stamp_in;
	logic [28:0] rx_ident_in;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] tx_frame_data, rx_data_in;
	int n_mismatch = 0, cmp_count = 0, n;
	// 50 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	can_mailbox_message_store can_mailbox_message_store_inst (.core_clk, .sys_rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .can_timer,
		.time_trig_mode, .tx_sof_sel, .tx_sof, .tx_done_sel, .tx_done, .tx_read_sel,
		.tx_send_request, .tx_byte_count_out, .tx_frame_data, .rx_push, .rx_push_fifo,
		.rx_ident_in, .rx_ident_format_in, .rx_frame_kind_in, .rx_stamp_in, .rx_filter_in,
		.rx_byte_count_in, .rx_data_in, .rx_release, .rx_fill_levels, .rx_overrun_r);
	can_node_model can_node_model_inst (.core_clk, .gap, .tx_send_request, .tx_sof,
		.tx_sof_sel, .tx_done, .tx_done_sel);
	// one apb transfer, held until pready; bounded wait
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk) penable <= 1'b1;
		n = 0;
		do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		n_mismatch += (n >= 20);
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		n_mismatch += (got !== exp);
		if (got !== exp)
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk({32'h0, rd}, {32'h0, e});
	endtask
	// one frame into fifo 0; stamp and filter follow the count
	task automatic rxp(input logic [28:0] id, input logic [1:0] fk, input logic [3:0] c);
		@(posedge core_clk);
		{rx_push, rx_ident_in, rx_ident_format_in, rx_frame_kind_in, rx_byte_count_in,
			rx_filter_in, rx_stamp_in} <= {1'b1, id, fk, c, {6{c}}};
		@(posedge core_clk) rx_push <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, rx_push, rx_release, rx_push_fifo} = '0;
		{rx_ident_in, rx_ident_format_in, rx_frame_kind_in, rx_byte_count_in} = '0;
		{rx_filter_in, rx_stamp_in, rx_data_in, tx_read_sel} = '0;
		{can_timer, time_trig_mode, gap, sys_rst} = {16'hABCD, 1'b1, 4'h8, 1'b1};
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		acc(1'b1, 8'h04, 32'hFFFF_FFF8);
		acc(1'b1, 8'h08, 32'h3322_1100);
		acc(1'b1, 8'h0C, 32'h7766_5544);
		rdc(8'h04, 32'h0000_0108);
		acc(1'b1, 8'h00, 32'h1);
		acc(1'b1, 8'h08, 32'h0);
		rdc(8'h08, 32'h3322_1100);
		while (tx_send_request !== 3'h0 && n++ < 99)
			@(posedge core_clk);
		chk({61'h0, tx_send_request}, 64'h0);
		chk(tx_frame_data, 64'hCDAB_5544_3322_1100);
		chk({60'h0, tx_byte_count_out}, 64'h8);
		rdc(8'h04, 32'hABCD_0108);
		rxp(29'h1ABC_DEF1, 2'h3, 4'h7);
		rxp(29'h1FFC_0000, 2'h0, 4'h9);
		rdc(8'h30, 32'hD5E6_F78E);
		acc(1'b1, 8'h34, 32'h0);
		rdc(8'h34, 32'h7777_7700);
		rx_release <= 2'h1;
		@(posedge core_clk) rx_release <= 2'h0;
		rdc(8'h30, 32'hFFE0_0000);
		rdc(8'h34, 32'h9999_9908);
		repeat (3) rxp(29'h0, 2'h0, 4'h1);
		@(posedge core_clk);
		chk({62'h0, rx_overrun_r}, 64'h1);
		chk({60'h0, rx_fill_levels}, 64'h3);
		acc(1'b1, 8'h50, 32'h0);
		chk({63'h0, err}, 64'h1);
		give_verdict();
	end
	// watchdog; a normal run takes a few microseconds
	initial
	begin
		#100us;
		n_mismatch++;
		give_verdict();
	end
endmodule // can_mailbox_message_store_tb
bind can_mailbox_message_store can_mailbox_chk can_mailbox_chk_inst (.core_clk, .sys_rst,
	.psel, .penable, .pready, .pslverr, .paddr, .tx_done, .tx_done_sel, .tx_send_request,
	.tx_byte_count_out, .rx_push, .rx_overrun_r);
`default_nettype wire
